// file: bench/host_rx_model.sv
// Purpose: Host receiver that samples the framer's serial pins
// Assumes: Host takes data on the rising edge of its clock
// Notes:   Newest bit sits at bit 0, so a frame's first bit is at cnt_o-1
`timescale 1ns/10ps
`default_nettype none
module host_rx_model (
    // Clock and reset
    input  wire logic    sys_clk_i,
    input  wire logic    rst_b_i,
    // Pin levels and host options
    input  wire logic    ck_i,
    input  wire logic    mk_i,
    input  wire logic    d_i,
    input  wire logic    efs_i,
    input  wire logic    cinv_i,
    input  wire logic    minv_i,
    // Capture
    output logic [127:0] bits_o,
    output logic [7:0]   cnt_o
);
    logic       ck_q_ff, rise, start;
    logic [3:0] run_ff;
    assign rise  = (ck_i ^ cinv_i) & ~ck_q_ff;
    assign start = efs_i ? (!d_i && run_ff >= 4'ha) : (mk_i ^ minv_i);
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            {ck_q_ff, bits_o, cnt_o} <= '0;
            run_ff <= 4'ha;
        end else begin
            ck_q_ff <= ck_i ^ cinv_i;
            if (rise) begin
                bits_o <= {bits_o[126:0], d_i};
                run_ff <= d_i ? run_ff + {3'h0, run_ff != 4'hf} : 4'h0;
                cnt_o  <= start ? 8'h01 : cnt_o + {7'h0, cnt_o != 8'h00 && cnt_o != 8'hff};
            end
        end
    end
endmodule // host_rx_model
`default_nettype wire

// file: bench/iq_serial_output_framer_chk.sv
// Purpose: Concurrent checks on the framer's serial pins and sample handshake
// Assumes: Options change only while reset is held
// Notes:   Clock and marker are judged after undoing their invert options
`timescale 1ns/10ps
`default_nettype none
module iq_serial_output_framer_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Options
    input wire logic embedded_sync_enable_i,
    input wire logic marker_tristate_select_i,
    input wire logic marker_invert_i,
    input wire logic out_clock_invert_i,
    input wire logic out_clock_tristate_i,
    // Stream and pins
    input wire logic sample_valid_i,
    input wire logic sample_ready_o,
    input wire logic frame_marker_o,
    input wire logic frame_marker_oe_o,
    input wire logic serial_clock_out_o,
    input wire logic serial_clock_out_oe_o,
    input wire logic primary_serial_output_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic       ck, mk, mk_q_ff, ck_q_ff, take, start;
    logic [2:0] pend_ff;
    logic [1:0] rise_ff;
    assign ck    = serial_clock_out_o ^ out_clock_invert_i;
    assign mk    = frame_marker_o ^ marker_invert_i;
    assign take  = sample_valid_i & sample_ready_o & clk_en_i;
    assign start = mk & ~mk_q_ff & ~embedded_sync_enable_i;
    // Pending samples and output clock rises seen under the marker
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            {mk_q_ff, ck_q_ff, pend_ff, rise_ff} <= '0;
        end else begin
            {mk_q_ff, ck_q_ff} <= {mk, ck};
            pend_ff <= pend_ff + {2'h0, take} - {2'h0, start};
            rise_ff <= mk ? rise_ff + {1'b0, ck & ~ck_q_ff & ~&rise_ff} : 2'h0;
        end
    end
    property p_mk_tri; (embedded_sync_enable_i && !marker_tristate_select_i) [*2] |-> !frame_marker_oe_o; endproperty
    a_mk_tri: assert property (p_mk_tri) else $error("marker driven while it should float");
    property p_mk_low; (embedded_sync_enable_i && marker_tristate_select_i) [*2]
        |-> frame_marker_oe_o && frame_marker_o == 1'b0; endproperty
    a_mk_low: assert property (p_mk_low) else $error("marker not held at its idle level");
    property p_ck_tri; out_clock_tristate_i [*2] |-> !serial_clock_out_oe_o; endproperty
    a_ck_tri: assert property (p_ck_tri) else $error("output clock driven while tristated");
    property p_ck_drv; !out_clock_tristate_i [*2] |-> serial_clock_out_oe_o; endproperty
    a_ck_drv: assert property (p_ck_drv) else $error("output clock not driven");
    property p_data_fall; $changed(primary_serial_output_o) |-> $fell(ck); endproperty
    a_data_fall: assert property (p_data_fall) else $error("data moved off a clock fall");
    property p_mk_start; start |-> $fell(ck); endproperty
    a_mk_start: assert property (p_mk_start) else $error("marker rose off a clock fall");
    property p_mk_width; $fell(mk) && !embedded_sync_enable_i |-> $fell(ck) && rise_ff == 2'h1; endproperty
    a_mk_width: assert property (p_mk_width) else $error("marker not one clock period wide");
    property p_one_frame; start |-> pend_ff != 3'h0; endproperty
    a_one_frame: assert property (p_one_frame) else $error("frame started without a sample");
    property p_depth; !embedded_sync_enable_i |-> pend_ff <= 3'h3; endproperty
    a_depth: assert property (p_depth) else $error("more samples taken than can be held");
endmodule // iq_serial_output_framer_chk
bind iq_serial_output_framer iq_serial_output_framer_chk i_iq_serial_output_framer_chk (.*);
`default_nettype wire

// file: bench/iq_serial_output_framer_tb.sv
// Purpose: Self-checking bench for the serial I/Q output framer
// Assumes: Options are changed only while reset is held
// Notes:   Frames are judged from what the host model captured
`timescale 1ns/10ps
`default_nettype none
module iq_serial_output_framer_tb;
    import iq_framer_pkg::*;
    logic sys_clk_i, rst_b_i, clk_en_i, word_long_i, gain_bytes_enable_i, gain_bytes_alternate_i;
    logic embedded_sync_enable_i, marker_tristate_select_i, marker_invert_i, marker_late_i, mod_reset_evt_i;
    logic out_clock_invert_i, out_clock_tristate_i, sample_valid_i, sample_ready_o, primary_serial_output_o;
    logic frame_marker_o, frame_marker_oe_o, serial_clock_out_o, serial_clock_out_oe_o, pat, ck_w, mk_w;
    logic [DIV_W-1:0] serial_out_rate_divider_i;
    logic [23:0]      i_word_i, q_word_i;
    logic [7:0]       atten_i, rx_cnt;
    logic [5:0]       rssi_i;
    logic [127:0]     rx_bits;
    int               n_fail, num_checks, waited;
    iq_serial_output_framer i_iq_serial_output_framer (.*);
    host_rx_model i_host_rx_model (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ck_i(ck_w), .mk_i(mk_w),
        .d_i(primary_serial_output_o), .efs_i(embedded_sync_enable_i), .cinv_i(out_clock_invert_i),
        .minv_i(marker_invert_i), .bits_o(rx_bits), .cnt_o(rx_cnt));
    // A released pin shows a changing pattern rather than its last level
    assign ck_w = serial_clock_out_oe_o ? serial_clock_out_o : pat;
    assign mk_w = frame_marker_oe_o ? frame_marker_o : pat;
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) pat <= ~pat;
    task automatic chk(input logic [127:0] s, input logic [127:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t ns: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic timeout;
        n_fail++;
        $display("Error at %0t ns: wait ran out", $time);
        test_done();
    endtask
    task automatic setup(input logic [8:0] c, input logic [7:0] d);
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        {word_long_i, gain_bytes_enable_i, gain_bytes_alternate_i, embedded_sync_enable_i, marker_tristate_select_i,
            marker_invert_i, marker_late_i, out_clock_invert_i, out_clock_tristate_i} <= c;
        serial_out_rate_divider_i <= d;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
    endtask
    // Offer one sample and hold it until the edge where ready is seen
    task automatic send(input logic [23:0] i, input logic [23:0] q, input logic [7:0] a, input logic [5:0] r);
        @(posedge sys_clk_i);
        {sample_valid_i, i_word_i, q_word_i, atten_i, rssi_i} <= {1'b1, i, q, a, r};
        for (waited = 0; waited < 400; waited++) begin
            @(negedge sys_clk_i);
            if (sample_ready_o === 1'b1) break;
        end
        @(posedge sys_clk_i);
        sample_valid_i <= 1'b0;
        if (waited == 400) timeout();
    endtask
    task automatic wait_bits(input int n);
        int k;
        for (k = 0; k < 3000 && rx_cnt === 8'(n); k++) @(negedge sys_clk_i);
        for (k = 0; k < 3000 && rx_cnt !== 8'(n); k++) @(negedge sys_clk_i);
        if (k == 3000) timeout();
    endtask
    task automatic t_three_wire;
        setup(9'b100000000, 8'h01);
        send(24'h812345, 24'h7fedcb, 8'h00, 6'h00);
        wait_bits(48);
        chk(rx_bits[47:0], {24'h812345, 24'h7fedcb});
        chk(frame_marker_oe_o, 1'b1);
        $display("three-wire test done");
    endtask
    task automatic t_gain;
        setup(9'b010001010, 8'h02);
        repeat (4) begin
            @(posedge sys_clk_i);
            mod_reset_evt_i <= 1'b1;
            @(posedge sys_clk_i);
            mod_reset_evt_i <= 1'b0;
        end
        send(24'ha5c311, 24'h3c5a22, 8'hff, 6'h3c);
        wait_bits(48);
        chk(rx_bits[47:0], {16'ha5c3, 16'h3c5a, 8'hff, 2'h3, 6'h3c});
        $display("gain byte test done");
    endtask
    // Four samples in a row: the last must be held off while the shifter is busy
    task automatic t_alt;
        setup(9'b111000000, 8'h01);
        fork
            begin
                for (int n = 0; n < 4; n++) send({8'(n), 16'ha5c3}, {16'h3c5a, 8'(n)}, 8'h81, 6'h14);
                chk(waited > 0, 1'b1);
            end
            begin
                for (int n = 0; n < 4; n++) begin
                    wait_bits(56);
                    chk(rx_bits[55:0], {8'(n), 16'ha5c3, 16'h3c5a, 8'(n), n[0] ? 8'h15 : 8'h80});
                end
            end
        join
        $display("alternate status test done");
    endtask
    task automatic t_sync;
        logic [31:0] w [2];
        logic [39:0] e;
        w[0] = 32'h1234abcd;
        w[1] = 32'h5a0ff0a5;
        setup(9'b000101100, 8'h01);
        send(24'h1234ff, 24'habcd11, 8'h00, 6'h00);
        send(24'h5a0f33, 24'hf0a577, 8'h00, 6'h00);
        for (int f = 0; f < 2; f++) begin
            wait_bits(40);
            for (int b = 0; b < 4; b++) e[39-10*b -: 10] = {1'b0, w[f][31-8*b -: 8], 1'b1};
            chk(rx_bits[39:0], e);
        end
        chk(frame_marker_oe_o, 1'b0);
        $display("embedded sync test done");
    endtask
    task automatic t_pins;
        setup(9'b000111011, 8'h01);
        repeat (3) @(negedge sys_clk_i);
        chk({frame_marker_oe_o, frame_marker_o}, 2'b10);
        chk(serial_clock_out_oe_o, 1'b0);
        $display("pin option test done");
    endtask
    initial begin
        {sys_clk_i, rst_b_i, word_long_i, gain_bytes_enable_i, gain_bytes_alternate_i, embedded_sync_enable_i,
            marker_tristate_select_i, marker_invert_i, marker_late_i, out_clock_invert_i, out_clock_tristate_i,
            sample_valid_i, mod_reset_evt_i, pat, i_word_i, q_word_i, atten_i, rssi_i} = '0;
        clk_en_i = 1'b1;
        serial_out_rate_divider_i = 8'h01;
        n_fail = 0;
        num_checks = 0;
        t_three_wire();
        t_gain();
        t_alt();
        t_sync();
        t_pins();
        test_done();
    end
endmodule // iq_serial_output_framer_tb
`default_nettype wire

// file: core/frame_shifter.sv
// Purpose: Serialises one sample into a frame on the output clock and data pins
// Assumes: Options held stable during a frame
// Notes:   One output bit per two sys_clk ticks times the divider
`timescale 1ns/10ps
`default_nettype none
module frame_shifter
    import iq_framer_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             clk_en_i,
    // Options
    input  wire logic             word_long_i,
    input  wire logic             gain_bytes_enable_i,
    input  wire logic             gain_bytes_alternate_i,
    input  wire logic             embedded_sync_enable_i,
    input  wire logic             marker_late_i,
    input  wire logic [DIV_W-1:0] rate_div_i,
    // Sample in
    sample_if.snk                 smp_s,
    // Raw outputs
    output logic                  sclk_o,
    output logic                  sdata_o,
    output logic                  marker_o,
    output logic                  frame_done_o
);
    frame_state_t               state_ff;
    logic [FRAME_MAX_BITS-1:0]  sr_ff;
    logic [CNT_W-1:0]           bits_ff;
    logic [DIV_W-1:0]           div_ff;
    logic                       sclk_ff;
    logic                       alt_sel_ff;
    logic                       first_ff;
    logic                       mark_ff;
    logic                       mark_pend_ff;
    logic [FRAME_MAX_BITS-1:0]  raw;
    logic [FRAME_MAX_BITS-1:0]  packed_v;
    logic [CNT_W-1:0]           raw_len;
    logic [CNT_W-1:0]           nbytes;
    logic [BYTE_W-1:0]          byte_a;
    logic [BYTE_W-1:0]          byte_b;

    wire tick     = clk_en_i && (div_ff == '0);
    wire fall     = tick && sclk_ff;
    wire [BYTE_W-1:0] rs_byte = {smp_s.data.rcnt, smp_s.data.rssi};

    assign byte_a = gain_bytes_alternate_i ?
                    (alt_sel_ff ? {rs_byte[7:1], 1'b1} : {smp_s.data.atten[7:1], 1'b0})
                    : smp_s.data.atten;
    assign byte_b = rs_byte;

    // frame assembly, MSB first, left justified
    always_comb begin
        raw     = '0;
        raw_len = '0;
        if (word_long_i) begin
            raw[FRAME_MAX_BITS-1 -: 48] = {smp_s.data.i_word, smp_s.data.q_word};
            raw_len = 7'd48;
        end else begin
            raw[FRAME_MAX_BITS-1 -: 32] = {smp_s.data.i_word[23:8], smp_s.data.q_word[23:8]};
            raw_len = 7'd32;
        end
        if (gain_bytes_enable_i) begin
            raw[FRAME_MAX_BITS-1-raw_len -: 16] = {byte_a, gain_bytes_alternate_i ? 8'h00 : byte_b};
            raw_len = raw_len + (gain_bytes_alternate_i ? 7'd8 : 7'd16);
        end
    end

    // start and stop bit wrapping per byte
    assign nbytes = raw_len >> 3;
    always_comb begin
        packed_v = '1;
        for (int k = 0; k < 8; k++) begin
            if (k < nbytes) begin
                packed_v[FRAME_MAX_BITS-1-10*k -: 10] = {1'b0, raw[FRAME_MAX_BITS-1-8*k -: 8], 1'b1};
            end
        end
    end

    assign smp_s.ready = clk_en_i && (state_ff == ST_IDLE) && tick && !sclk_ff;
    assign sclk_o      = sclk_ff;
    // Idle level until the first fall, so data never moves on a rising edge
    assign sdata_o     = sr_ff[FRAME_MAX_BITS-1] | (state_ff != ST_SHIFT) | first_ff;
    assign marker_o    = mark_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            div_ff <= '0;
            sclk_ff <= 1'b0;
        end else if (clk_en_i) begin
            div_ff <= (div_ff == '0) ? rate_div_i - 8'h01 : div_ff - 8'h01;
            if (div_ff == '0) begin
                sclk_ff <= ~sclk_ff;
            end
        end
    end

    // one frame per sample, idle tail
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_ff     <= ST_IDLE;
            sr_ff        <= '1;
            bits_ff      <= '0;
            alt_sel_ff   <= 1'b0;
            first_ff     <= 1'b0;
            mark_ff      <= 1'b0;
            mark_pend_ff <= 1'b0;
            frame_done_o <= 1'b0;
        end else if (clk_en_i) begin
            frame_done_o <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (smp_s.valid && smp_s.ready) begin
                        sr_ff      <= embedded_sync_enable_i ? packed_v : raw;
                        bits_ff    <= embedded_sync_enable_i ? (nbytes * 7'd10) : raw_len;
                        alt_sel_ff <= gain_bytes_enable_i ? ~alt_sel_ff : alt_sel_ff;
                        first_ff   <= 1'b1;
                        state_ff   <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (fall) begin
                        // marker one bit wide, optionally one clock late
                        mark_pend_ff <= first_ff;
                        mark_ff      <= !embedded_sync_enable_i && (marker_late_i ? mark_pend_ff : first_ff);
                        first_ff     <= 1'b0;
                        if (!first_ff) begin
                            sr_ff   <= {sr_ff[FRAME_MAX_BITS-2:0], 1'b1};
                            bits_ff <= bits_ff - 7'd1;
                            if (bits_ff == 7'd1) begin
                                bits_ff  <= embedded_sync_enable_i ? IDLE_HIGH_CNT : 7'd0;
                                state_ff <= ST_TAIL;
                            end
                        end
                    end
                end
                ST_TAIL: begin
                    if (fall) begin
                        mark_ff      <= 1'b0;
                        mark_pend_ff <= 1'b0;
                        if (bits_ff == '0) begin
                            frame_done_o <= 1'b1;
                            state_ff     <= ST_IDLE;
                        end else begin
                            bits_ff <= bits_ff - 7'd1;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule : frame_shifter
`default_nettype wire

// file: core/iq_framer_pkg.sv
// Purpose: Shared constants and types for the serial I/Q output framer
// Assumes: One system clock at 20 MHz
// Notes:   Frame layout and widths are named here once
package iq_framer_pkg;
    localparam int          WORD_W_LONG    = 24;
    localparam int          WORD_W_SHORT   = 16;
    localparam int          BYTE_W         = 8;
    localparam int          RSSI_W         = 6;
    localparam int          RCNT_W         = 2;
    localparam logic [1:0]  RCNT_MAX       = 2'h3;
    localparam logic [5:0]  RSSI_FULLSCALE = 6'h3c;
    localparam int          FRAME_MAX_BITS = 120;
    localparam int          IDLE_HIGH_BITS = 10;
    localparam int          CNT_W          = 7;
    localparam logic [6:0]  IDLE_HIGH_CNT  = 7'h0a;
    localparam int          DIV_W          = 8;
    localparam logic [7:0]  DIV_RESET      = 8'h01;
    localparam int          DEC_W          = 16;
    localparam logic [15:0] DEC_RESET      = 16'h0030;

    typedef struct packed {
        logic [WORD_W_LONG-1:0] i_word;
        logic [WORD_W_LONG-1:0] q_word;
        logic [BYTE_W-1:0]      atten;
        logic [RCNT_W-1:0]      rcnt;
        logic [RSSI_W-1:0]      rssi;
    } sample_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_TAIL  = 2'b11
    } frame_state_t;
endpackage : iq_framer_pkg

// file: core/iq_serial_output_framer.sv
// Purpose: Serial I/Q output framer, 3-wire or 2-wire embedded sync
// Assumes: Decimated samples arrive on sys_clk with a valid strobe
// Notes:   Pins are registered once so clock, data and marker move together
// Summary of operation
// - Three-wire mode drives frame marker, output clock and serial data.
// - Two-wire mode embeds framing in data; only clock and data used.
// - One frame per decimated sample; rate is modulator clock over decimation.
// - I word then Q word, 24 or 16 bits, MSB first, two's complement.
// - Two status bytes follow Q only when gain bytes enabled.
// - First status byte is attenuation, 0 none to 255 at 24 dB.
// - Second status byte is 2-bit reset count and 6-bit strength.
// - Reset count counts modulator resets since last report, saturating at 3; code clears it on every sample taken, reported or not.
// - Strength is linear estimate after first decimation; 60 is full scale.
// - Alternate clear: both status bytes follow as one 16-bit word.
// - Alternate set: one status byte per frame, alternating attenuation and strength.
// - Alternate mode forces attenuation LSB to 0, strength byte LSB to 1.
// - Embedded sync wraps each byte with low start and high stop bit.
// - Embedded sync ends each frame with at least ten high bits.
// - Embedded sync holds marker low or tristated, tristate by default.
// - Marker invert flips marker polarity.
// - Late marker delays marker one output clock; ignored in embedded sync.
// - Clock invert flips output clock; clock tristate releases it.
`timescale 1ns/10ps
`default_nettype none
module iq_serial_output_framer
    import iq_framer_pkg::*;
(
    // Clock, reset, enable
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             clk_en_i,
    // Configuration
    input  wire logic             word_long_i,
    input  wire logic             gain_bytes_enable_i,
    input  wire logic             gain_bytes_alternate_i,
    input  wire logic             embedded_sync_enable_i,
    input  wire logic             marker_tristate_select_i,
    input  wire logic             marker_invert_i,
    input  wire logic             marker_late_i,
    input  wire logic             out_clock_invert_i,
    input  wire logic             out_clock_tristate_i,
    input  wire logic [DIV_W-1:0] serial_out_rate_divider_i,
    // Decimated sample input
    input  wire logic             sample_valid_i,
    output logic                  sample_ready_o,
    input  wire logic [23:0]      i_word_i,
    input  wire logic [23:0]      q_word_i,
    input  wire logic [7:0]       atten_i,
    input  wire logic [5:0]       rssi_i,
    input  wire logic             mod_reset_evt_i,
    // Serial pins
    output logic                  frame_marker_o,
    output logic                  frame_marker_oe_o,
    output logic                  serial_clock_out_o,
    output logic                  serial_clock_out_oe_o,
    output logic                  primary_serial_output_o
);
    sample_if in_s ();
    sample_if buf_s ();

    logic [RCNT_W-1:0] rcnt_ff;
    logic              sclk_raw;
    logic              sdata_raw;
    logic              mark_raw;
    logic              sclk_q_ff;
    logic              sdata_q_ff;
    logic              mark_q_ff;

    wire take = sample_valid_i && in_s.ready && clk_en_i;

    assign in_s.data        = {i_word_i, q_word_i, atten_i, rcnt_ff, rssi_i};
    assign in_s.valid       = sample_valid_i;
    assign sample_ready_o   = in_s.ready;

    // saturating reset count, cleared on every sample taken; new event wins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rcnt_ff <= '0;
        end else if (clk_en_i) begin
            if (take) begin
                rcnt_ff <= {1'b0, mod_reset_evt_i};
            end else if (mod_reset_evt_i && rcnt_ff != RCNT_MAX) begin
                rcnt_ff <= rcnt_ff + 2'h1;
            end
        end
    end

    sample_skid_buf u_buf (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .clk_en_i  (clk_en_i),
        .in_s      (in_s),
        .out_s     (buf_s)
    );

    frame_shifter u_shift (
        .sys_clk_i              (sys_clk_i),
        .rst_b_i                (rst_b_i),
        .clk_en_i               (clk_en_i),
        .word_long_i            (word_long_i),
        .gain_bytes_enable_i    (gain_bytes_enable_i),
        .gain_bytes_alternate_i (gain_bytes_alternate_i),
        .embedded_sync_enable_i (embedded_sync_enable_i),
        .marker_late_i          (marker_late_i),
        .rate_div_i             (serial_out_rate_divider_i),
        .smp_s                  (buf_s),
        .sclk_o                 (sclk_raw),
        .sdata_o                (sdata_raw),
        .marker_o               (mark_raw),
        .frame_done_o           ()
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sclk_q_ff  <= 1'b0;
            sdata_q_ff <= 1'b1;
            mark_q_ff  <= 1'b0;
        end else if (clk_en_i) begin
            sclk_q_ff  <= sclk_raw;
            sdata_q_ff <= sdata_raw;
            mark_q_ff  <= mark_raw;
        end
    end

    // pin drive, clock invert and tristate
    assign serial_clock_out_o      = sclk_q_ff ^ out_clock_invert_i;
    assign serial_clock_out_oe_o   = !out_clock_tristate_i;
    assign primary_serial_output_o = sdata_q_ff;
    // marker polarity and release in embedded sync
    assign frame_marker_o    = embedded_sync_enable_i ? 1'b0 : (mark_q_ff ^ marker_invert_i);
    assign frame_marker_oe_o = !(embedded_sync_enable_i && !marker_tristate_select_i);
endmodule : iq_serial_output_framer
`default_nettype wire

// file: core/sample_if.sv
// Purpose: Valid/ready carrier for one frame's sample between framer modules
// Assumes: Single clock domain
// Notes:   Source drives data and valid, sink drives ready
`timescale 1ns/10ps
`default_nettype none
interface sample_if;
    import iq_framer_pkg::*;
    sample_t data;
    logic    valid;
    logic    ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sample_if
`default_nettype wire

// file: core/sample_skid_buf.sv
// Purpose: Two-entry buffer in the sample path so a stalled shifter loses nothing
// Assumes: Single clock, synchronous active-low reset
// Notes:   Ready toward the source drops only when both entries are full
`timescale 1ns/10ps
`default_nettype none
module sample_skid_buf
    import iq_framer_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic clk_en_i,
    // Stream sides
    sample_if.snk     in_s,
    sample_if.src     out_s
);
    sample_t mem_ff [2];
    logic    wr_ptr_ff;
    logic    rd_ptr_ff;
    logic [1:0] cnt_ff;
    wire push = in_s.valid && in_s.ready && clk_en_i;
    wire pop  = out_s.valid && out_s.ready && clk_en_i;

    assign in_s.ready  = (cnt_ff != 2'h2);
    assign out_s.valid = (cnt_ff != 2'h0);
    assign out_s.data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_s.data;
        end
    end
endmodule : sample_skid_buf
`default_nettype wire
